// ==== rtl/rtc_host_port.sv ====
// Host port, command decode, rollover flag, interrupts and compare of the calendar clock
module rtc_host_port #(
	parameter int CMP_CYC = rtc_pkg::CMP_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Count ticks, same domain
	input wire logic kilo_tick,
	input wire logic osc_tick,
	// Host bus pins
	input wire rtc_pkg::ctl_pins_t ctl_pins,
	input wire logic [4:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic rdy_n_out,
	output logic rdy_n_oe,
	// Interrupt pins
	output logic main_irq,
	output logic main_irq_oe,
	output logic sby_irq_n_out,
	output logic sby_irq_n_oe,
	// Status
	output logic test_mode
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (CMP_CYC < 2 || CMP_CYC > 65535) begin : g_bad_cmp
		$error("CMP_CYC out of range");
	end

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	rtc_pkg::ctl_pins_t sync1_ff, sync2_ff, sync3_ff, ctl_ff, nxt_ctl;

	always_comb begin
		nxt_ctl = ctl_ff;
		// Change counts once second and third stage agree [RULE25]
		for (int i = 0; i < 4; i++) begin
			if (sync2_ff[i] == sync3_ff[i]) begin
				nxt_ctl[i] = sync3_ff[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= rtc_pkg::CTL_IDLE;
			sync2_ff <= rtc_pkg::CTL_IDLE;
			sync3_ff <= rtc_pkg::CTL_IDLE;
			ctl_ff <= rtc_pkg::CTL_IDLE;
		end else if (ce) begin
			sync1_ff <= ctl_pins;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			ctl_ff <= nxt_ctl;
		end
	end

	// ----------------------------------------
	// Strobe decode
	// ----------------------------------------
	logic pd_ok, rd_act, wr_act, rd_start, rd_end, wr_start, cyc_start, wr_fire;
	logic rd_prev_ff, wr_prev_ff, is_wr_ff, nxt_is_wr;
	logic [1:0] rdy_cnt_ff, nxt_rdy_cnt;
	logic [4:0] addr_ff, nxt_addr;

	// Power-down shuts the bus off completely [RULE1]
	assign pd_ok = ctl_ff.pd_n;
	// Strobes count only with select [RULE13]
	assign rd_act = pd_ok && !ctl_ff.cs_n && !ctl_ff.rd_n;
	assign wr_act = pd_ok && !ctl_ff.cs_n && !ctl_ff.wr_n;
	assign rd_start = rd_act && !rd_prev_ff;
	assign rd_end = !rd_act && rd_prev_ff;
	assign wr_start = wr_act && !wr_prev_ff;
	assign cyc_start = rd_start || wr_start;
	// Data latched as ready releases; early strobe end drops the write
	assign wr_fire = is_wr_ff && wr_act && rdy_cnt_ff == 2'h1;

	always_comb begin
		nxt_addr = addr_ff;
		nxt_is_wr = is_wr_ff;
		nxt_rdy_cnt = rdy_cnt_ff;
		if (rdy_cnt_ff != 2'h0) begin
			nxt_rdy_cnt = rdy_cnt_ff - 2'h1;
		end
		if (cyc_start) begin
			// Address held stable by the host through the strobe [RULE14]
			nxt_addr = addr;
			nxt_is_wr = wr_start;
			nxt_rdy_cnt = rtc_pkg::RDY_CYC; // [RULE12]
		end
		if (!pd_ok) begin
			nxt_rdy_cnt = rtc_pkg::RST_RDY_CNT;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_prev_ff <= 1'b0;
			wr_prev_ff <= 1'b0;
			is_wr_ff <= 1'b0;
			rdy_cnt_ff <= rtc_pkg::RST_RDY_CNT;
			addr_ff <= 5'h00;
		end else if (ce) begin
			rd_prev_ff <= rd_act;
			wr_prev_ff <= wr_act;
			is_wr_ff <= nxt_is_wr;
			rdy_cnt_ff <= nxt_rdy_cnt;
			addr_ff <= nxt_addr;
		end
	end

	// ----------------------------------------
	// Counters, RAM, flags
	// ----------------------------------------
	logic [7:0] cnt_ff [8];
	logic [7:0] nxt_cnt [8];
	logic [7:0] ram_ff [8];
	logic [7:0] nxt_ram [8];
	logic [7:0] irq_ctl_ff, nxt_irq_ctl, irq_st_ff, nxt_irq_st, irq_ev, rd_mux;
	logic [7:0] data_ff, nxt_data;
	logic roll_ff, nxt_roll, seen_ff, nxt_seen, sby_en_ff, nxt_sby_en;
	logic cmp_ff, nxt_cmp, cmp_ev, match, count_tick, test_ff, nxt_test;
	logic [15:0] cmp_dly_ff, nxt_cmp_dly;
	logic [8:0] inc_csec, inc_sec, inc_min, inc_hour;
	logic ms_carry;

	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max);
		if (v == max) begin
			bcd_inc = 9'h100;
		end else if (v[3:0] == 4'h9) begin
			bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Raw oscillator replaces the 1 kHz tick in test mode [RULE15]
	assign nxt_test = wr_act && addr == rtc_pkg::ADDR_FACTORY_TEST_ENTRY;
	assign count_tick = test_ff ? osc_tick : kilo_tick;
	assign ms_carry = cnt_ff[rtc_pkg::IDX_MSEC][7:4] == 4'h9;
	assign inc_csec = bcd_inc(cnt_ff[rtc_pkg::IDX_CSEC], rtc_pkg::MAX_CSEC);
	assign inc_sec = bcd_inc(cnt_ff[rtc_pkg::IDX_SEC], rtc_pkg::MAX_SEC);
	assign inc_min = bcd_inc(cnt_ff[rtc_pkg::IDX_MIN], rtc_pkg::MAX_MIN);
	assign inc_hour = bcd_inc(cnt_ff[rtc_pkg::IDX_HOUR], rtc_pkg::MAX_HOUR);

	always_comb begin
		match = 1'b1;
		rd_mux = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i == rtc_pkg::IDX_MSEC) begin
				match = match && ((cnt_ff[i] ^ ram_ff[i]) & rtc_pkg::RAM_MASK_MSEC) == 8'h00;
			end else if (i == 5) begin
				match = match && ((cnt_ff[i] ^ ram_ff[i]) & rtc_pkg::RAM_MASK_WEEKDAY) == 8'h00;
			end else begin
				match = match && cnt_ff[i] == ram_ff[i];
			end
		end
		if (addr < rtc_pkg::ADDR_RAM_BASE) begin
			rd_mux = cnt_ff[addr[2:0]];
		end else if (addr < rtc_pkg::ADDR_IRQ_STATUS) begin
			rd_mux = ram_ff[addr[2:0]];
		end else if (addr == rtc_pkg::ADDR_IRQ_STATUS) begin
			rd_mux = irq_st_ff;
		end else if (addr == rtc_pkg::ADDR_IRQ_CONTROL) begin
			rd_mux = irq_ctl_ff;
		end else if (addr == rtc_pkg::ADDR_ROLLOVER_FLAG) begin
			rd_mux = {7'h00, roll_ff}; // [RULE8]
		end
	end

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_ram = ram_ff;
		nxt_irq_ctl = irq_ctl_ff;
		nxt_sby_en = sby_en_ff;
		nxt_data = data_ff;
		nxt_seen = seen_ff;
		nxt_roll = roll_ff;
		nxt_irq_st = irq_st_ff;
		nxt_cmp = cmp_ff;
		nxt_cmp_dly = cmp_dly_ff;
		irq_ev = 8'h00;
		cmp_ev = 1'b0;
		// Timekeeping runs in power-down too [RULE1]
		if (count_tick) begin
			nxt_cnt[rtc_pkg::IDX_MSEC] = ms_carry ? 8'h00 : cnt_ff[rtc_pkg::IDX_MSEC] + 8'h10;
			if (ms_carry) begin
				nxt_cnt[rtc_pkg::IDX_CSEC] = inc_csec[7:0];
				irq_ev[1] = cnt_ff[rtc_pkg::IDX_CSEC][3:0] == 4'h9;
				irq_ev[2] = inc_csec[8];
				if (inc_csec[8]) begin
					nxt_cnt[rtc_pkg::IDX_SEC] = inc_sec[7:0];
					irq_ev[3] = inc_sec[8];
					if (inc_sec[8]) begin
						nxt_cnt[rtc_pkg::IDX_MIN] = inc_min[7:0];
						irq_ev[4] = inc_min[8];
						if (inc_min[8]) begin
							nxt_cnt[rtc_pkg::IDX_HOUR] = inc_hour[7:0];
							irq_ev[5] = inc_hour[8];
						end
					end
				end
			end
			nxt_cmp_dly = 16'(CMP_CYC);
		end
		// Compare sampled once the ripple has settled [RULE20]
		if (cmp_dly_ff == 16'h0001) begin
			nxt_cmp = match;
			cmp_ev = match;
		end
		if (cmp_dly_ff != 16'h0000) begin
			nxt_cmp_dly = count_tick ? 16'(CMP_CYC) : cmp_dly_ff - 16'h0001;
		end
		irq_ev[0] = cmp_ev;
		if (cyc_start) begin
			nxt_data = rd_mux;
		end
		if (wr_fire) begin
			if (addr_ff < rtc_pkg::ADDR_RAM_BASE) begin
				nxt_cnt[addr_ff[2:0]] = data_in;
			end else if (addr_ff < rtc_pkg::ADDR_IRQ_STATUS) begin
				nxt_ram[addr_ff[2:0]] = data_in;
			end else if (addr_ff == rtc_pkg::ADDR_IRQ_CONTROL) begin
				nxt_irq_ctl = data_in;
			end else if (addr_ff == rtc_pkg::ADDR_BACKUP_IRQ_ENABLE) begin
				nxt_sby_en = data_in[0]; // [RULE24]
			end else if (addr_ff == rtc_pkg::ADDR_COUNTER_CLEAR_CMD && data_in == rtc_pkg::CLEAR_KEY) begin
				for (int i = 0; i < 8; i++) begin
					nxt_cnt[i] = rtc_pkg::RST_BYTE; // [RULE3]
				end
			end else if (addr_ff == rtc_pkg::ADDR_ALARM_RAM_CLEAR_CMD && data_in == rtc_pkg::CLEAR_KEY) begin
				for (int i = 0; i < 8; i++) begin
					nxt_ram[i] = rtc_pkg::RST_BYTE; // [RULE3]
				end
			end else if (addr_ff == rtc_pkg::ADDR_SECONDS_RESTART_CMD) begin
				// Data lines not looked at [RULE5]
				nxt_cnt[rtc_pkg::IDX_MSEC] = rtc_pkg::RST_BYTE; // [RULE4]
				nxt_cnt[rtc_pkg::IDX_CSEC] = rtc_pkg::RST_BYTE; // [RULE4]
				nxt_cnt[rtc_pkg::IDX_SEC] = rtc_pkg::RST_BYTE; // [RULE4]
				nxt_cnt[rtc_pkg::IDX_MIN] = cnt_ff[rtc_pkg::IDX_SEC] > rtc_pkg::RESTART_SEC_LIMIT ?
					inc_min[7:0] : cnt_ff[rtc_pkg::IDX_MIN]; // [RULE6]
			end
		end
		// Counter reads arm the rollover watch
		if (rd_start && addr < rtc_pkg::ADDR_RAM_BASE) begin
			nxt_seen = 1'b1;
		end
		if (rd_end && addr_ff == rtc_pkg::ADDR_ROLLOVER_FLAG) begin
			nxt_roll = 1'b0; // [RULE9]
			nxt_seen = 1'b0;
		end
		// Set after clear so a coincident tick is not lost [RULE7]
		if (count_tick && (seen_ff || (rd_act && addr_ff < rtc_pkg::ADDR_RAM_BASE))) begin
			nxt_roll = 1'b1;
		end
		if (rd_end && addr_ff == rtc_pkg::ADDR_IRQ_STATUS) begin
			nxt_irq_st = 8'h00; // [RULE23]
		end
		nxt_irq_st = nxt_irq_st | (irq_ev & irq_ctl_ff); // [RULE16]
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				cnt_ff[i] <= rtc_pkg::RST_BYTE;
				ram_ff[i] <= rtc_pkg::RST_BYTE;
			end
			irq_ctl_ff <= rtc_pkg::RST_BYTE;
			irq_st_ff <= rtc_pkg::RST_BYTE;
			data_ff <= rtc_pkg::RST_BYTE;
			sby_en_ff <= 1'b0;
			seen_ff <= 1'b0;
			roll_ff <= 1'b0;
			cmp_ff <= 1'b0;
			cmp_dly_ff <= 16'h0000;
			test_ff <= 1'b0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
			ram_ff <= nxt_ram;
			irq_ctl_ff <= nxt_irq_ctl;
			irq_st_ff <= nxt_irq_st;
			data_ff <= nxt_data;
			sby_en_ff <= nxt_sby_en;
			seen_ff <= nxt_seen;
			roll_ff <= nxt_roll;
			cmp_ff <= nxt_cmp;
			cmp_dly_ff <= nxt_cmp_dly;
			test_ff <= nxt_test;
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	logic oe_ff, main_oe_ff, irq_ff, sby_oe_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			oe_ff <= 1'b0;
			main_oe_ff <= 1'b0;
			irq_ff <= 1'b0;
			sby_oe_ff <= 1'b0;
		end else if (ce) begin
			oe_ff <= rd_act && !rd_start;
			main_oe_ff <= pd_ok; // [RULE1]
			irq_ff <= |irq_st_ff; // [RULE17]
			// Backup alarm follows compare level, even in power-down [RULE18] [RULE19]
			sby_oe_ff <= sby_en_ff && cmp_ff;
		end
	end

	assign data_out = data_ff;
	assign data_oe = oe_ff;
	assign rdy_n_out = 1'b0;
	assign rdy_n_oe = rdy_cnt_ff != 2'h0;
	assign main_irq = irq_ff;
	assign main_irq_oe = main_oe_ff;
	assign sby_irq_n_out = 1'b0;
	assign sby_irq_n_oe = sby_oe_ff;
	assign test_mode = test_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_pd_quiet: assert property (ce && !pd_ok |=> !rdy_n_oe && !main_irq_oe && !data_oe) // [RULE1]
		else $error("outputs active in power-down");
	chk_cnt_clear: assert property (ce && wr_fire && addr_ff == rtc_pkg::ADDR_COUNTER_CLEAR_CMD && // [RULE3]
		data_in == rtc_pkg::CLEAR_KEY |=> cnt_ff[rtc_pkg::IDX_SEC] == 8'h00 && cnt_ff[rtc_pkg::IDX_HOUR] == 8'h00)
		else $error("counter clear missed");
	chk_ram_clear: assert property (ce && wr_fire && addr_ff == rtc_pkg::ADDR_ALARM_RAM_CLEAR_CMD && // [RULE3]
		data_in == rtc_pkg::CLEAR_KEY |=> ram_ff[3] == 8'h00 && ram_ff[7] == 8'h00)
		else $error("ram clear missed");
	chk_restart_clear: assert property (ce && wr_fire && addr_ff == rtc_pkg::ADDR_SECONDS_RESTART_CMD |=> // [RULE4]
		cnt_ff[rtc_pkg::IDX_SEC] == 8'h00 && cnt_ff[rtc_pkg::IDX_CSEC] == 8'h00)
		else $error("restart did not clear seconds");
	chk_restart_minute: assert property (ce && wr_fire && addr_ff == rtc_pkg::ADDR_SECONDS_RESTART_CMD |=> // [RULE6]
		(cnt_ff[rtc_pkg::IDX_MIN] != $past(cnt_ff[rtc_pkg::IDX_MIN])) ==
		($past(cnt_ff[rtc_pkg::IDX_SEC]) > rtc_pkg::RESTART_SEC_LIMIT))
		else $error("restart minute step wrong");
	chk_roll_set: assert property (ce && count_tick && seen_ff |=> roll_ff) // [RULE7]
		else $error("rollover not flagged");
	chk_roll_read: assert property (ce && cyc_start && addr == rtc_pkg::ADDR_ROLLOVER_FLAG |=> // [RULE8]
		data_out == {7'h00, $past(roll_ff)})
		else $error("rollover read value wrong");
	chk_roll_clear: assert property (ce && rd_end && addr_ff == rtc_pkg::ADDR_ROLLOVER_FLAG && // [RULE9]
		!count_tick |=> !roll_ff)
		else $error("rollover not cleared");
	chk_ready_low: assert property (ce && cyc_start && pd_ok ##1 ce && pd_ok // [RULE12]
		##1 ce && pd_ok && !cyc_start |-> rdy_n_oe && $past(rdy_n_oe) ##1 !rdy_n_oe)
		else $error("ready pulse width wrong");
	chk_irq_off: assert property (ce && rd_end && addr_ff == rtc_pkg::ADDR_IRQ_STATUS && // [RULE17]
		(irq_ev & irq_ctl_ff) == 8'h00 ##1 ce && (irq_ev & irq_ctl_ff) == 8'h00 |=> !main_irq)
		else $error("main interrupt not released");
	chk_sby_on: assert property (ce && sby_en_ff && cmp_ev ##1 ce && sby_en_ff |=> sby_irq_n_oe) // [RULE18]
		else $error("backup alarm not driven");
	chk_test_entry: assert property (ce && wr_act && addr == rtc_pkg::ADDR_FACTORY_TEST_ENTRY |=> // [RULE15]
		test_mode)
		else $error("test mode not entered");
endmodule

// ==== rtl/rtc_pkg.sv ====
// Constants, address map and carrier types for the calendar clock host port
// Functional notes
// [RULE1] Power-down low: bus ignored, outputs off except backup alarm, time keeps running.
// [RULE2] Host programs backup alarm enable before pulling power-down low.
// [RULE3] Writing FF clears all time counters, or at the other location all alarm RAM.
// [RULE4] Seconds restart write clears thousandths through tens-of-seconds counters.
// [RULE5] Seconds restart ignores the data lines.
// [RULE6] Restart with seconds above 39 advances minutes by one, else minutes unchanged.
// [RULE7] Rollover flag sets on any count tick during or after a counter read; a first-cycle tick sets it only with seen_ff set or a counter in addr_ff.
// [RULE8] Rollover location reads flag on data_lsb, all other bits zero.
// [RULE9] Trailing edge of a rollover location read clears the flag.
// [RULE10] Host reads rollover flag after single read or after last of a sequence.
// [RULE11] Host repeats counter reads when rollover flag found set.
// [RULE12] Ready pulls low at cycle start until read data valid or write latched.
// [RULE13] Host asserts read or write strobe only together with device select.
// [RULE14] Host holds address stable while select and a strobe are low.
// [RULE15] Select, write strobe and address 1F held: test mode, raw oscillator drives counting.
// [RULE16] Main interrupt rises within 5 us of a status register event.
// [RULE17] Main interrupt falls within 5 us of the status read trailing edge.
// [RULE18] Enabled backup alarm drives low within 5 us of compare valid.
// [RULE19] Writing zero to backup enable floats the backup alarm within 5 us.
// [RULE20] Compare valid 61 us after the count tick, only when counters equal RAM.
// [RULE21] Host deselects at least 500 ns between counter reads.
// [RULE22] Host holds select and write 1050 ns after write data changes.
// [RULE23] Main interrupt clears when the status register read ends.
// [RULE24] data_lsb one enables backup alarm, zero disables; it follows compare level.
// [RULE25] Select and strobes are synchronised so each strobe acts exactly once.
package rtc_pkg;
	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam logic [4:0] ADDR_RAM_BASE = 5'h08;
	localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
	localparam logic [4:0] ADDR_IRQ_CONTROL = 5'h11;
	localparam logic [4:0] ADDR_COUNTER_CLEAR_CMD = 5'h12;
	localparam logic [4:0] ADDR_ALARM_RAM_CLEAR_CMD = 5'h13;
	localparam logic [4:0] ADDR_ROLLOVER_FLAG = 5'h14;
	localparam logic [4:0] ADDR_SECONDS_RESTART_CMD = 5'h15;
	localparam logic [4:0] ADDR_BACKUP_IRQ_ENABLE = 5'h16;
	localparam logic [4:0] ADDR_FACTORY_TEST_ENTRY = 5'h1F;
	localparam logic [7:0] CLEAR_KEY = 8'hFF;
	localparam logic [7:0] RESTART_SEC_LIMIT = 8'h39;
	// ----------------------------------------
	// Counter byte indices and limits
	// ----------------------------------------
	localparam int IDX_MSEC = 0;
	localparam int IDX_CSEC = 1;
	localparam int IDX_SEC = 2;
	localparam int IDX_MIN = 3;
	localparam int IDX_HOUR = 4;
	localparam logic [7:0] MAX_CSEC = 8'h99;
	localparam logic [7:0] MAX_SEC = 8'h59;
	localparam logic [7:0] MAX_MIN = 8'h59;
	localparam logic [7:0] MAX_HOUR = 8'h23;
	localparam logic [7:0] RAM_MASK_MSEC = 8'hF0;
	localparam logic [7:0] RAM_MASK_WEEKDAY = 8'h0F;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_RDY_CNT = 2'h0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int CMP_DELAY_US = 61;
	localparam int CMP_DELAY_CYC = (CMP_DELAY_US * 1000) / CLK_PERIOD_NS;
	localparam int IRQ_MAX_US = 5;
	localparam int IRQ_MAX_CYC = (IRQ_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam logic [1:0] RDY_CYC = 2'h2;
	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic pd_n;
	} ctl_pins_t;
	localparam ctl_pins_t CTL_IDLE = 4'hF;
endpackage

// ==== sim/host_master.sv ====
// Bus master model for the calendar clock host port
module host_master (
	// Clock and answer
	input wire logic clk,
	input wire logic rdy_n_oe,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	// Bus drive
	output rtc_pkg::ctl_pins_t ctl_pins,
	output logic [4:0] addr,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		ctl_pins = rtc_pkg::CTL_IDLE;
		addr = 5'h00;
		data_in = 8'h5A;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Caller programs the backup enable first
	task automatic set_pd(input logic v);
		ctl_pins.pd_n = v;
		step(8);
	endtask
	// Address and data settle first; strobe only under select
	task automatic begin_cycle(input logic wr, input logic [4:0] a, input logic [7:0] d);
		addr = a;
		data_in = wr ? d : ~data_in;
		step(25);
		ctl_pins.cs_n = 1'b0;
		ctl_pins.rd_n = wr;
		ctl_pins.wr_n = !wr;
	endtask
	// Hold, then a long deselect gap between reads
	task automatic end_cycle();
		ctl_pins.cs_n = 1'b1;
		ctl_pins.rd_n = 1'b1;
		ctl_pins.wr_n = 1'b1;
		step(30);
		// Released lines show the inverse, not a stale value
		addr = ~addr;
		data_in = ~data_in;
		step(100);
	endtask
	// Strobe held until ready is released, then data taken
	task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q, output int rdy, output logic oe);
		int w;
		w = 0;
		rdy = 0;
		begin_cycle(wr, a, d);
		while (!rdy_n_oe && w < 30) begin
			step(1);
			w++;
		end
		while (rdy_n_oe && rdy < 8) begin
			step(1);
			rdy++;
		end
		q = data_out;
		oe = data_oe;
		end_cycle();
	endtask
endmodule

// ==== sim/rtc_host_port_and_control_tb.sv ====
// Self-checking bench for the calendar clock host port
module rtc_host_port_and_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// Short compare delay keeps the run brief
	localparam int CMP = 20;
	localparam logic [4:0] ZERO_AT [6] = '{5'h12, 5'h13, 5'h15, 5'h16, 5'h17, 5'h1F};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic kilo_tick = 1'b0;
	logic osc_tick = 1'b0;
	rtc_pkg::ctl_pins_t ctl_pins;
	logic [4:0] addr;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe;
	logic rdy_n_oe;
	logic rdy_n_out;
	logic sby_irq_n_out;
	logic main_irq;
	logic main_irq_oe;
	logic sby_irq_n_oe;
	logic test_mode;
	int err_total = 0;
	int check_count = 0;
	int ms = 0;
	logic seen = 1'b0;
	logic rf = 1'b0;
	logic [31:0] rs = 32'h00004F5B;
	// --------------------------------
	// Clock, design and host
	// --------------------------------
	always #2 clk = ~clk;
	rtc_host_port #(.CMP_CYC(CMP)) rtc_host_port_inst (
		.clk(clk), .rst_n(rst_n), .ce(ce), .kilo_tick(kilo_tick), .osc_tick(osc_tick),
		.ctl_pins(ctl_pins), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.rdy_n_out(rdy_n_out), .rdy_n_oe(rdy_n_oe), .main_irq(main_irq), .main_irq_oe(main_irq_oe),
		.sby_irq_n_out(sby_irq_n_out), .sby_irq_n_oe(sby_irq_n_oe), .test_mode(test_mode)
	);
	host_master host_master_inst (
		.clk(clk), .rdy_n_oe(rdy_n_oe), .data_out(data_out), .data_oe(data_oe),
		.ctl_pins(ctl_pins), .addr(addr), .data_in(data_in)
	);
	// --------------------------------
	// Model helpers and checks
	// --------------------------------
	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction
	function automatic logic [7:0] bcd(input int n);
		return {4'(n / 10), 4'(n % 10)};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One count tick; the model flag follows a prior counter read
	task automatic tk(input logic osc);
		step(1);
		osc_tick = osc;
		kilo_tick = !osc;
		step(1);
		osc_tick = 1'b0;
		kilo_tick = 1'b0;
		ms++;
		rf = rf | seen;
	endtask
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		int r;
		logic o;
		host_master_inst.access(w, a, d, q, r, o);
		chk(8'(r), {6'h00, rtc_pkg::RDY_CYC});
		chk({7'h00, o}, {7'h00, !w});
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(q, e);
		if (a < 5'h08) begin
			seen = 1'b1;
		end
	endtask
	task automatic ro();
		rd(rtc_pkg::ADDR_ROLLOVER_FLAG, {7'h00, rf});
		rf = 1'b0;
		seen = 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// About two and a half times the expected run
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end
	initial begin
		int s;
		int m;
		int n;
		logic [7:0] d;
		logic [7:0] q;
		logic o;
		step(5);
		rst_n = 1'b1;
		step(3);
		chk({rdy_n_out, sby_irq_n_out, data_oe, rdy_n_oe, main_irq, sby_irq_n_oe, test_mode, main_irq_oe},
			8'h01);
		foreach (ZERO_AT[i]) begin
			rd(ZERO_AT[i], 8'h00);
		end
		for (int i = 0; i < 3; i++) begin
			s = (i == 2) ? int'(rnd()) % 60 : 39 + i;
			m = int'(rnd()) % 59;
			wr(5'h03, bcd(m));
			wr(5'h02, bcd(s));
			d = rnd();
			wr(rtc_pkg::ADDR_SECONDS_RESTART_CMD, d);
			rd(5'h00, 8'h00);
			rd(5'h01, 8'h00);
			rd(5'h02, 8'h00);
			rd(5'h03, bcd(s > 39 ? m + 1 : m));
		end
		d = rnd();
		wr(5'h0A, d);
		rd(5'h0A, d);
		wr(rtc_pkg::ADDR_ALARM_RAM_CLEAR_CMD, rtc_pkg::CLEAR_KEY);
		rd(5'h0A, 8'h00);
		wr(5'h04, 8'h17);
		wr(rtc_pkg::ADDR_COUNTER_CLEAR_CMD, rtc_pkg::CLEAR_KEY);
		rd(5'h03, 8'h00);
		rd(5'h04, 8'h00);
		ms = 0;
		host_master_inst.begin_cycle(1'b1, rtc_pkg::ADDR_FACTORY_TEST_ENTRY, 8'h00);
		step(8);
		chk({7'h00, test_mode}, 8'h01);
		tk(1'b1);
		host_master_inst.end_cycle();
		chk({7'h00, test_mode}, 8'h00);
		rd(5'h00, {4'(ms), 4'h0});
		ro();
		ro();
		rd(5'h02, 8'h00);
		ro();
		rd(5'h02, 8'h00);
		tk(1'b0);
		ro();
		rd(5'h00, {4'(ms), 4'h0});
		ro();
		wr(5'h08, {4'(ms + 1), 4'h0});
		wr(rtc_pkg::ADDR_IRQ_CONTROL, 8'h01);
		wr(rtc_pkg::ADDR_BACKUP_IRQ_ENABLE, 8'h01);
		host_master_inst.set_pd(1'b0);
		chk({7'h00, main_irq_oe}, 8'h00);
		host_master_inst.access(1'b1, 5'h02, 8'h22, q, n, o);
		chk({o, 7'(n)}, 8'h00);
		tk(1'b0);
		n = 0;
		while (!sby_irq_n_oe && n < 1300) begin
			step(1);
			n++;
		end
		chk({7'h00, n >= CMP - 1 && n <= CMP + rtc_pkg::IRQ_MAX_CYC}, 8'h01);
		step(4);
		chk({7'h00, main_irq}, 8'h01);
		host_master_inst.set_pd(1'b1);
		rd(5'h02, 8'h00);
		rd(rtc_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk({7'h00, main_irq}, 8'h00);
		d = rnd();
		wr(rtc_pkg::ADDR_BACKUP_IRQ_ENABLE, d & 8'hFE);
		chk({7'h00, sby_irq_n_oe}, 8'h00);
		wr(rtc_pkg::ADDR_BACKUP_IRQ_ENABLE, 8'h01);
		chk({7'h00, sby_irq_n_oe}, 8'h01);
		// Every counter one tick from rollover, all rate interrupts on
		wr(5'h00, 8'h90);
		wr(5'h01, 8'h99);
		wr(5'h02, 8'h59);
		wr(5'h03, 8'h59);
		wr(5'h04, 8'h23);
		wr(rtc_pkg::ADDR_IRQ_CONTROL, 8'h3E);
		// Clock enable low must swallow a tick
		ce = 1'b0;
		kilo_tick = 1'b1;
		step(2);
		kilo_tick = 1'b0;
		ce = 1'b1;
		rd(5'h00, 8'h90);
		tk(1'b0);
		step(4);
		chk({7'h00, main_irq}, 8'h01);
		rd(rtc_pkg::ADDR_IRQ_STATUS, 8'h3E);
		rd(5'h04, 8'h00);
		rd(5'h03, 8'h00);
		rd(rtc_pkg::ADDR_IRQ_CONTROL, 8'h3E);
		ro();
		chk({7'h00, sby_irq_n_oe}, 8'h00);
		wrap_up();
	end
endmodule
